// *** rtl/rxcal_pkg.sv ***
package rxcal_pkg;
  localparam int WORD_W = 24;
  localparam int CTRL2_LSB = 0;
  localparam logic [1:0] SEL_SYNTH = 2'h2;
  localparam logic [1:0] SEL_FILT = 2'h3;
  localparam logic [2:0] SEL_CAL = 3'h5;
  localparam logic [2:0] SEL_CONTROL_TX = 3'h1;
  localparam logic [2:0] SEL_CONTROL = 3'h0;
  localparam int PHASE_LSB = 18;
  localparam int BANDCLK_LSB = 16;
  localparam int CALSTART_BIT = 15;
  localparam int CALDIV_LSB = 9;
  localparam int TMO_LSB = 3;
  localparam int PRESC_LSB = 22;
  localparam int CPGAIN_BIT = 21;
  localparam int FBSRC_BIT = 20;
  localparam int BCNT_LSB = 7;
  localparam int ACNT_LSB = 2;
  localparam int BOOST_BIT = 7;
  localparam int BW_LSB = 5;
  localparam int GAIN_LSB = 2;
  localparam logic [1:0] BANDCLK_DIV8 = 2'h3;
  localparam logic [2:0] PHASE_OFF = 3'h7;
  localparam int CLK_HZ = 10000000;
  localparam int SCLK_MAX_HZ = 20000000;
  localparam int SCLK_HALF_CYC = (CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
endpackage : rxcal_pkg

// *** rtl/rxcal_if.sv ***
`timescale 1ns/1ps
interface rxcal_if;
  logic sclk;
  logic serial_data_pin;
  logic load_enable_pin;
  modport dev (input sclk, input serial_data_pin, input load_enable_pin);
  modport host (output sclk, output serial_data_pin, output load_enable_pin);
endinterface : rxcal_if

// *** rtl/rxcal_dev.sv ***
`timescale 1ns/1ps
module rxcal_dev
  import rxcal_pkg::*;
(
  input  wire logic          I_CLK,
  input  wire logic          I_RESETN,
  rxcal_if.dev               LINK,
  input  wire logic          I_REF_TICK,
  output logic [2:0]         O_MOD_PHASE,
  output logic [1:0]         O_BAND_CLK_DIV,
  output logic               O_CAL_START,
  output logic               O_CAL_CLK,
  output logic               O_BOOST,
  output logic [1:0]         O_PRESCALER,
  output logic               O_CP_MAX,
  output logic               O_FB_MUX,
  output logic [12:0]        O_B_COUNT,
  output logic [4:0]         O_A_COUNT,
  output logic [1:0]         O_RX_BW,
  output logic [2:0]         O_RX_GAIN
);
  import rxcal_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  logic [2:0] sclk_s, serial_data_pin_s, sle_s;
  logic [WORD_W-1:0] shift_r, cal_r, synth_r, filt_r;
  logic [5:0] div_cnt_r, tmo_cnt_r, cal_div, tmo;
  logic load, sclk_rise, cal_tick_r;
  assign sclk_rise = sclk_s[1] & ~sclk_s[2];
  assign load = sle_s[1] & ~sle_s[2];
  assign cal_div = cal_r[CALDIV_LSB +: 6];
  assign tmo = cal_r[TMO_LSB +: 6];
  always_ff @(posedge I_CLK or negedge I_RESETN)
    if (!I_RESETN)
    begin
      sclk_s <= 3'h0;
      serial_data_pin_s <= 3'h0;
      sle_s <= 3'h0;
    end
    else
    begin
      sclk_s <= {sclk_s[1:0], LINK.sclk};
      serial_data_pin_s <= {serial_data_pin_s[1:0], LINK.serial_data_pin};
      sle_s <= {sle_s[1:0], LINK.load_enable_pin};
    end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge I_CLK or negedge I_RESETN)
    if (!I_RESETN)
      shift_r <= '0;
    else if (sclk_rise)
      shift_r <= {shift_r[WORD_W-2:0], serial_data_pin_s[1]};
  always_ff @(posedge I_CLK or negedge I_RESETN)
    if (!I_RESETN)
    begin
      cal_r <= '0;
      synth_r <= '0;
      filt_r <= '0;
      O_CAL_START <= 1'b0;
    end
    else
    begin
      O_CAL_START <= load && shift_r[2:0] == SEL_CAL && shift_r[CALSTART_BIT];
      if (load && shift_r[2:0] == SEL_CAL)
        cal_r <= shift_r;
      else if (load && shift_r[1:0] == SEL_SYNTH)
        synth_r <= shift_r;
      else if (load && shift_r[1:0] == SEL_FILT)
        filt_r <= shift_r;
    end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge I_CLK or negedge I_RESETN)
    if (!I_RESETN)
    begin
      div_cnt_r <= 6'h00;
      cal_tick_r <= 1'b0;
      O_CAL_CLK <= 1'b0;
    end
    else
    begin
      cal_tick_r <= 1'b0;
      if (I_REF_TICK)
      begin
        if (div_cnt_r + 6'h01 >= cal_div)
        begin
          div_cnt_r <= 6'h00;
          cal_tick_r <= 1'b1;
          O_CAL_CLK <= 1'b1;
        end
        else
        begin
          div_cnt_r <= div_cnt_r + 6'h01;
          O_CAL_CLK <= (div_cnt_r + 6'h01) < (cal_div >> 1);
        end
      end
    end
  always_ff @(posedge I_CLK or negedge I_RESETN)
    if (!I_RESETN)
      tmo_cnt_r <= 6'h00;
    else if (O_CAL_START)
      tmo_cnt_r <= tmo;
    else if (cal_tick_r && tmo_cnt_r != 6'h00)
      tmo_cnt_r <= tmo_cnt_r - 6'h01;
  always_ff @(posedge I_CLK or negedge I_RESETN)
    if (!I_RESETN)
    begin
      O_BOOST <= 1'b0;
      O_MOD_PHASE <= 3'h0;
      O_BAND_CLK_DIV <= 2'h0;
      O_PRESCALER <= 2'h0;
      O_CP_MAX <= 1'b0;
      O_FB_MUX <= 1'b0;
      O_B_COUNT <= 13'h0000;
      O_A_COUNT <= 5'h00;
      O_RX_BW <= 2'h0;
      O_RX_GAIN <= 3'h0;
    end
    else
    begin
      O_BOOST <= (tmo == 6'h00) ? filt_r[BOOST_BIT] : (tmo_cnt_r != 6'h00);
      O_MOD_PHASE <= cal_r[PHASE_LSB +: 3];
      O_BAND_CLK_DIV <= cal_r[BANDCLK_LSB +: 2];
      O_PRESCALER <= synth_r[PRESC_LSB +: 2];
      O_CP_MAX <= synth_r[CPGAIN_BIT];
      O_FB_MUX <= synth_r[FBSRC_BIT];
      O_B_COUNT <= synth_r[BCNT_LSB +: 13];
      O_A_COUNT <= synth_r[ACNT_LSB +: 5];
      O_RX_BW <= filt_r[BW_LSB +: 2];
      O_RX_GAIN <= filt_r[GAIN_LSB +: 3];
    end
endmodule : rxcal_dev

// *** rtl/rxcal_host.sv ***
`timescale 1ns/1ps
module rxcal_host
  import rxcal_pkg::*;
(
  input  wire logic              I_CLK,
  input  wire logic              I_RESETN,
  input  wire logic              I_WR,
  input  wire logic [WORD_W-1:0] I_WORD,
  output logic                   O_BUSY,
  rxcal_if.host                  LINK
);
  import rxcal_pkg::*;
  typedef enum logic [3:0] {S_IDLE = 4'h1, S_LOW = 4'h2, S_HIGH = 4'h4, S_LE = 4'h8} rxcal_st_type;
  rxcal_st_type st_r;
  logic [WORD_W-1:0] word_r;
  logic [4:0] bit_r;
  logic [7:0] half_r;
  logic sclk_r, sle_r;
  assign LINK.sclk = sclk_r;
  assign LINK.serial_data_pin = word_r[WORD_W-1];
  assign LINK.load_enable_pin = sle_r;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge I_CLK or negedge I_RESETN)
    if (!I_RESETN)
    begin
      st_r <= S_IDLE;
      word_r <= '0;
      bit_r <= 5'h00;
      half_r <= 8'h00;
      sclk_r <= 1'b0;
      sle_r <= 1'b0;
      O_BUSY <= 1'b0;
    end
    else
    begin
      case (st_r)
        S_IDLE:
        begin
          sle_r <= 1'b0;
          if (I_WR)
          begin
            word_r <= I_WORD;
            bit_r <= 5'h00;
            half_r <= 8'h00;
            O_BUSY <= 1'b1;
            st_r <= S_LOW;
          end
          else
            O_BUSY <= 1'b0;
        end
        S_LOW:
          if (half_r + 8'h01 >= 8'(SCLK_HALF_CYC))
          begin
            half_r <= 8'h00;
            sclk_r <= 1'b1;
            st_r <= S_HIGH;
          end
          else
            half_r <= half_r + 8'h01;
        S_HIGH:
          if (half_r + 8'h01 >= 8'(SCLK_HALF_CYC))
          begin
            half_r <= 8'h00;
            sclk_r <= 1'b0;
            word_r <= {word_r[WORD_W-2:0], 1'b0};
            bit_r <= bit_r + 5'h01;
            st_r <= (bit_r == 5'(WORD_W - 1)) ? S_LE : S_LOW;
          end
          else
            half_r <= half_r + 8'h01;
        S_LE:
        begin
          sle_r <= 1'b1;
          st_r <= S_IDLE;
        end
        default:
          st_r <= S_IDLE;
      endcase
    end
endmodule : rxcal_host

// *** sim/rxcal_chk.sv ***
`timescale 1ns/1ps
module rxcal_chk (
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic sclk,
  input wire logic serial_data_pin,
  input wire logic load_enable_pin
);
  logic [5:0] cnt_r;
  logic       sclk_r;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);
  ////////////////////////////////////////////////////////////////
  // Remember the serial clock level of the last cycle.
  always_ff @(posedge I_CLK or negedge I_RESETN)
    if (!I_RESETN) sclk_r <= 1'b0;
    else sclk_r <= sclk;
  // Count serial clock rises since the last load pulse.
  always_ff @(posedge I_CLK or negedge I_RESETN)
    if (!I_RESETN) cnt_r <= 6'h00;
    else if (load_enable_pin) cnt_r <= 6'h00;
    else if (sclk && !sclk_r) cnt_r <= cnt_r + 6'h01;
  ////////////////////////////////////////////////////////////////
  AST_SCLK_HIGH1: assert property ($rose(sclk) |=> !sclk)
    else $error("serial clock high too long");
  AST_DATA_HOLD: assert property (sclk |-> $stable(serial_data_pin))
    else $error("data moved while clock high");
  AST_SLE_ONE: assert property ($rose(load_enable_pin) |=> !load_enable_pin)
    else $error("load pulse too long");
  AST_SLE_QUIET: assert property (load_enable_pin |-> !sclk)
    else $error("clock during load");
  AST_COUNT24: assert property ($rose(load_enable_pin) |-> cnt_r == 6'h18)
    else $error("load without 24 bits");
  AST_NO_OVER: assert property (cnt_r <= 6'h18)
    else $error("more than 24 bits");
  AST_SLE_DUE: assert property ((cnt_r == 6'h18 && $fell(sclk)) |-> ##[0:4] load_enable_pin)
    else $error("load pulse missing");
  AST_IDLE_LOW: assert property ($fell(load_enable_pin) |-> !sclk && cnt_r == 6'h00)
    else $error("clock left running");
  COV_LOAD: cover property ($rose(load_enable_pin));
  COV_FULL: cover property (cnt_r == 6'h18);
  COV_ONE: cover property (sclk && serial_data_pin);
endmodule : rxcal_chk

// *** sim/tb_rxcal_lo_rx_latch_bank.sv ***
`timescale 1ns/1ps
module tb_rxcal_lo_rx_latch_bank;
  import rxcal_pkg::*;
  logic I_CLK = 0, I_RESETN = 0, wr = 0, calstart, calclk, boost, cp, fb;
  logic [23:0] word = 0, sh = 0, last_w = 0;
  logic [2:0] ph, gain;
  logic [1:0] bclk, presc, bw;
  logic [12:0] bc;
  logic [4:0] ac;
  logic busy, sclk_q = 0, sle_q = 0;
  int errors = 0, checks = 0, cyc = 0, starts = 0, bcnt = 0;
  logic [49:0] rows [9] = '{{24'hE001FE, 2'd0, 24'h38007F}, {24'h5FFF82, 2'd0, 24'h17FFE0},
    {24'h000057, 2'd1, 24'h000015}, {24'h00003F, 2'd1, 24'h00000F}, {24'h1F0005, 2'd2, 24'h00001F},
    {24'h0B0005, 2'd2, 24'h00000B}, {24'hFFFFF9, 2'd0, 24'h17FFE0}, {24'hFFFFF8, 2'd1, 24'h00000F},
    {24'hFFFFFC, 2'd2, 24'h00000B}};
  rxcal_if lnk ();
  rxcal_host rxcal_host_i (.I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_WR(wr), .I_WORD(word), .O_BUSY(busy), .LINK(lnk));
  rxcal_dev rxcal_dev_i (.I_CLK(I_CLK), .I_RESETN(I_RESETN), .LINK(lnk), .I_REF_TICK(1'b1), .O_MOD_PHASE(ph),
    .O_BAND_CLK_DIV(bclk), .O_CAL_START(calstart), .O_CAL_CLK(calclk), .O_BOOST(boost), .O_PRESCALER(presc),
    .O_CP_MAX(cp), .O_FB_MUX(fb), .O_B_COUNT(bc), .O_A_COUNT(ac), .O_RX_BW(bw), .O_RX_GAIN(gain));
  rxcal_chk rxcal_chk_i (.I_CLK(I_CLK), .I_RESETN(I_RESETN), .sclk(lnk.sclk), .serial_data_pin(lnk.serial_data_pin), .load_enable_pin(lnk.load_enable_pin));
  ////////////////////////////////////////////////////////////////
  initial
  begin
    forever #50 I_CLK = ~I_CLK;
  end
  // Capture the word on the wire, count pulses and time out.
  always @(posedge I_CLK)
  begin
    sclk_q <= lnk.sclk;
    sle_q <= lnk.load_enable_pin;
    if (lnk.sclk === 1'b1 && !sclk_q) sh <= {sh[22:0], lnk.serial_data_pin};
    if (lnk.load_enable_pin === 1'b1 && !sle_q) last_w <= sh;
    starts <= starts + (calstart === 1'b1);
    bcnt <= bcnt + (boost === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 8000) errors++;
    if (cyc == 8000) complete_run();
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    checks++;
    if (g !== e) errors++;
    if (g !== e) $display("[ERR] %s exp %h got %h", nm, e, g);
  endtask : chk
  task automatic wrt(input logic [23:0] w);
    int n;
    @(posedge I_CLK) #10 wr = 1;
    word = w;
    @(posedge I_CLK) #10 wr = 0;
    for (n = 0; n < 200 && busy !== 1'b0; n++) @(posedge I_CLK);
    repeat (8) @(posedge I_CLK);
    #10 chk("wire_word", w, last_w);
  endtask : wrt
  function automatic logic [31:0] obs(input logic [1:0] s);
    return s == 0 ? {presc, cp, fb, bc, ac} : s == 1 ? {bw, gain} : {ph, bclk};
  endfunction : obs
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge I_CLK);
    chk("reset", 0, {ph, bclk, calstart, calclk, boost, presc, cp, fb, bc, ac, bw, gain});
    #10 I_RESETN = 1;
    foreach (rows[i])
    begin
      wrt(rows[i][49:26]);
      chk("latch", rows[i][23:0], obs(rows[i][25:24]));
    end
    starts = 0;
    wrt(24'h1F8005);
    chk("cal_start", 1, starts);
    starts = 0;
    wrt(24'h1F0005);
    chk("cal_idle", 0, starts);
    wrt(24'h000083);
    chk("boost_on", 1, boost);
    wrt(24'h000003);
    chk("boost_off", 0, boost);
    bcnt = 0;
    wrt(24'h1F821D);
    repeat (40) @(posedge I_CLK);
    chk("boost_len", 3, bcnt);
    #10 I_RESETN = 0;
    repeat (2) @(posedge I_CLK);
    #10 chk("reset_mid", 0, {ph, bclk, calstart, calclk, boost, presc, cp, fb, bc, ac, bw, gain});
    I_RESETN = 1;
    wrt(24'h0B0005);
    chk("after_reset", 24'h00000B, obs(2'd2));
    complete_run();
  end
endmodule : tb_rxcal_lo_rx_latch_bank
